// >>> logic/pmcl_phy_link.sv
`timescale 1ns/1ps
// What this block does
// - Receive data and data-valid appear no sooner than eight bit times after carrier sense rises.
// - Carrier sense rises at most 20 bit times after start of J.
// - Carrier sense falls 13 to 28 bit times after start of T when not transmitting.
// - Collision rises at most 20 bit times after J when transmitting.
// - Collision falls 13 to 28 bit times after start of T.
// - Carrier sense rises within 4 bit times after transmit enable is sampled high.
// - Carrier sense falls within 16 bit times after transmit enable is sampled low when not receiving.
// - Line output starts 6 to 14 bit times after transmit enable sampled high.
// - 10BASE-T link is lost after 50 to 150 ms without valid activity.
module pmcl_phy_link #(
   parameter int unsigned LINK_TX_CYC     = pmcl_pkg::LINK_TX_MS * pmcl_pkg::CYC_PER_MS,
   parameter int unsigned LINK_MIN_RX_CYC = pmcl_pkg::LINK_MIN_RX_MS * pmcl_pkg::CYC_PER_MS,
   parameter int unsigned LINK_LOSS_CYC   = pmcl_pkg::LINK_LOSS_MS * pmcl_pkg::CYC_PER_MS,
   parameter int          BUF_DEPTH       = pmcl_pkg::BUF_DEPTH
) (
   input  wire logic                      clk_i,
   input  wire logic                      sys_rst_i,
   input  wire logic                      link_clk_i,
   input  wire logic                      speed_100_i,
   input  wire logic                      tx_en_i,
   input  wire logic                      rx_sym_valid_i,
   input  wire logic [1:0]                rx_sym_kind_i,
   input  wire logic [pmcl_pkg::NIB_W-1:0] rx_sym_data_i,
   input  wire logic                      line_link_pulse_i,
   output logic                           rx_sym_ready_o,
   output logic                           crs_o,
   output logic                           col_o,
   output logic                           twisted_pair_out_positive_o,
   output logic                           link_pulse_o,
   output logic                           link_up_o,
   output logic [pmcl_pkg::NIB_W-1:0]     rxd_o,
   output logic                           rx_dv_o
);

   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CNT_W = $clog2(BUF_DEPTH + 1);
   localparam int LW    = pmcl_pkg::LINK_CNT_W;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link-domain reset and the system-side synchronisers

   logic rst_l1_reg;
   logic rst_l2_reg;
   logic rst_b1_reg;
   logic rst_b2_reg;
   logic lrst_reg;
   logic lrst_next;
   logic tx_s1_reg;
   logic tx_s2_reg;
   logic ack_s1_reg;
   logic ack_s2_reg;
   logic tx_en_reg;
   logic ack_reg;

   // A short reset may fall between two slow nibble clock edges, so the
   // link-domain reset is held until that domain reports it has seen it
   always_comb begin
      lrst_next = lrst_reg;
      if (rst_b2_reg) begin
         lrst_next = 1'b0;
      end
   end

   always_ff @(posedge link_clk_i) begin
      rst_l1_reg <= lrst_reg;
      rst_l2_reg <= rst_l1_reg;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lrst_reg   <= 1'b1;
         rst_b1_reg <= 1'b0;
         rst_b2_reg <= 1'b0;
         tx_s1_reg  <= 1'b0;
         tx_s2_reg  <= 1'b0;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end else begin
         lrst_reg   <= lrst_next;
         rst_b1_reg <= rst_l2_reg;
         rst_b2_reg <= rst_b1_reg;
         tx_s1_reg  <= tx_en_reg;
         tx_s2_reg  <= tx_s1_reg;
         ack_s1_reg <= ack_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive sequencer: carrier, collision, data-valid gate

   pmcl_pkg::pmcl_rx_state_type rx_state_reg;
   pmcl_pkg::pmcl_rx_state_type rx_state_next;
   logic [pmcl_pkg::RX_CNT_W-1:0] rx_cnt_reg;
   logic [pmcl_pkg::RX_CNT_W-1:0] rx_cnt_next;
   logic                          crs_rx_reg;
   logic                          crs_rx_next;
   logic                          drain_ok_reg;
   logic                          drain_ok_next;
   logic                          crs_reg;
   logic                          col_reg;
   logic                          sym_take;
   logic                          buf_full;

   assign rx_sym_ready_o = ~buf_full;
   assign sym_take       = rx_sym_valid_i & ~buf_full;

   always_comb begin
      rx_state_next = rx_state_reg;
      rx_cnt_next   = rx_cnt_reg;
      crs_rx_next   = crs_rx_reg;
      drain_ok_next = drain_ok_reg;
      case (rx_state_reg)
         pmcl_pkg::RX_IDLE: begin
            if (sym_take && rx_sym_kind_i == pmcl_pkg::SYM_J) begin
               rx_state_next = pmcl_pkg::RX_WAIT_CRS;
               rx_cnt_next   = pmcl_pkg::RX_CNT_ONE;
               drain_ok_next = 1'b0;
            end
         end
         pmcl_pkg::RX_WAIT_CRS: begin
            if (rx_cnt_reg == pmcl_pkg::RX_CRS_ON_CYC) begin
               rx_state_next = pmcl_pkg::RX_CARRIER;
               rx_cnt_next   = pmcl_pkg::RX_CNT_ONE;
               crs_rx_next   = 1'b1;
            end else begin
               rx_cnt_next = rx_cnt_reg + pmcl_pkg::RX_CNT_ONE;
            end
         end
         pmcl_pkg::RX_CARRIER: begin
            if (rx_cnt_reg == pmcl_pkg::RX_DV_LAG_CYC) begin
               drain_ok_next = 1'b1;
            end else begin
               rx_cnt_next = rx_cnt_reg + pmcl_pkg::RX_CNT_ONE;
            end
            if (sym_take && rx_sym_kind_i == pmcl_pkg::SYM_T) begin
               rx_state_next = pmcl_pkg::RX_END_WAIT;
               rx_cnt_next   = pmcl_pkg::RX_CNT_ONE;
               drain_ok_next = 1'b1;
            end
         end
         pmcl_pkg::RX_END_WAIT: begin
            if (rx_cnt_reg == pmcl_pkg::RX_CRS_OFF_CYC) begin
               rx_state_next = pmcl_pkg::RX_IDLE;
               rx_cnt_next   = pmcl_pkg::RX_CNT_ZERO;
               crs_rx_next   = 1'b0;
            end else begin
               rx_cnt_next = rx_cnt_reg + pmcl_pkg::RX_CNT_ONE;
            end
         end
         default: begin
            rx_state_next = pmcl_pkg::RX_IDLE;
            rx_cnt_next   = pmcl_pkg::RX_CNT_ZERO;
            crs_rx_next   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_state_reg <= pmcl_pkg::RX_IDLE;
         rx_cnt_reg   <= pmcl_pkg::RX_CNT_ZERO;
         crs_rx_reg   <= 1'b0;
         drain_ok_reg <= 1'b0;
         crs_reg      <= 1'b0;
         col_reg      <= 1'b0;
      end else begin
         rx_state_reg <= rx_state_next;
         rx_cnt_reg   <= rx_cnt_next;
         crs_rx_reg   <= crs_rx_next;
         drain_ok_reg <= drain_ok_next;
         crs_reg      <= crs_rx_reg | tx_s2_reg;
         col_reg      <= crs_rx_reg & tx_s2_reg;
      end
   end

   assign crs_o = crs_reg;
   assign col_o = col_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry receive buffer; a stalled drain pushes back on the symbol source

   logic [pmcl_pkg::WORD_W-1:0] buf_mem_reg  [BUF_DEPTH];
   logic [pmcl_pkg::WORD_W-1:0] buf_mem_next [BUF_DEPTH];
   logic [PTR_W-1:0]            wr_ptr_reg;
   logic [PTR_W-1:0]            wr_ptr_next;
   logic [PTR_W-1:0]            rd_ptr_reg;
   logic [PTR_W-1:0]            rd_ptr_next;
   logic [CNT_W-1:0]            buf_cnt_reg;
   logic [CNT_W-1:0]            buf_cnt_next;
   logic                        buf_push;
   logic                        buf_pop;
   logic                        buf_empty;
   logic                        hs_busy;
   logic                        hs_req_reg;
   logic                        hs_req_next;
   logic [pmcl_pkg::WORD_W-1:0] hs_data_reg;
   logic [pmcl_pkg::WORD_W-1:0] hs_data_next;

   assign buf_full  = (buf_cnt_reg == CNT_W'(BUF_DEPTH));
   assign buf_empty = (buf_cnt_reg == '0);
   assign hs_busy   = hs_req_reg ^ ack_s2_reg;
   // Data during the lead-in and the end marker are kept; J itself is not
   assign buf_push  = sym_take && ((rx_sym_kind_i == pmcl_pkg::SYM_DATA && rx_state_reg != pmcl_pkg::RX_IDLE)
                      || (rx_sym_kind_i == pmcl_pkg::SYM_T && rx_state_reg == pmcl_pkg::RX_CARRIER));
   assign buf_pop   = ~buf_empty & ~hs_busy & drain_ok_reg;

   always_comb begin
      buf_mem_next = buf_mem_reg;
      wr_ptr_next  = wr_ptr_reg;
      rd_ptr_next  = rd_ptr_reg;
      buf_cnt_next = buf_cnt_reg;
      if (buf_push) begin
         buf_mem_next[wr_ptr_reg] = {rx_sym_kind_i == pmcl_pkg::SYM_DATA, rx_sym_data_i};
         wr_ptr_next = ptr_inc(wr_ptr_reg);
      end
      if (buf_pop) begin
         rd_ptr_next = ptr_inc(rd_ptr_reg);
      end
      if (buf_push && !buf_pop) begin
         buf_cnt_next = buf_cnt_reg + CNT_W'(1);
      end else if (buf_pop && !buf_push) begin
         buf_cnt_next = buf_cnt_reg - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < BUF_DEPTH; i++) begin
            buf_mem_reg[i] <= '0;
         end
         wr_ptr_reg  <= '0;
         rd_ptr_reg  <= '0;
         buf_cnt_reg <= '0;
      end else begin
         buf_mem_reg <= buf_mem_next;
         wr_ptr_reg  <= wr_ptr_next;
         rd_ptr_reg  <= rd_ptr_next;
         buf_cnt_reg <= buf_cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Toggle handshake carrying one word at a time to the link domain

   always_comb begin
      hs_req_next  = hs_req_reg;
      hs_data_next = hs_data_reg;
      if (buf_pop) begin
         hs_req_next  = ~hs_req_reg;
         hs_data_next = buf_mem_reg[rd_ptr_reg];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hs_req_reg  <= 1'b0;
         hs_data_reg <= '0;
      end else begin
         hs_req_reg  <= hs_req_next;
         hs_data_reg <= hs_data_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: samples transmit enable, drives receive nibbles

   logic                      req_s1_reg;
   logic                      req_s2_reg;
   logic                      req_s3_reg;
   logic [pmcl_pkg::NIB_W-1:0] rxd_reg;
   logic                      rx_dv_reg;

   always_ff @(posedge link_clk_i) begin
      if (rst_l2_reg) begin
         tx_en_reg  <= 1'b0;
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
         ack_reg    <= 1'b0;
         rxd_reg    <= '0;
         rx_dv_reg  <= 1'b0;
      end else begin
         tx_en_reg  <= tx_en_i;
         req_s1_reg <= hs_req_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
         ack_reg    <= req_s2_reg;
         // Data word is stable while the request is outstanding
         if (req_s2_reg != req_s3_reg) begin
            rx_dv_reg <= hs_data_reg[pmcl_pkg::WORD_W-1];
            rxd_reg   <= hs_data_reg[pmcl_pkg::NIB_W-1:0];
         end
      end
   end

   assign rxd_o   = rxd_reg;
   assign rx_dv_o = rx_dv_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit line latency: fixed delay line, so both edges keep the same lag

   logic [pmcl_pkg::TX_LINE_CYC-1:0] tx_pipe_reg;
   logic [pmcl_pkg::TX_LINE_CYC-1:0] tx_pipe_next;

   always_comb begin
      tx_pipe_next = {tx_pipe_reg[pmcl_pkg::TX_LINE_CYC-2:0], tx_s2_reg};
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_pipe_reg <= '0;
      end else begin
         tx_pipe_reg <= tx_pipe_next;
      end
   end

   assign twisted_pair_out_positive_o = tx_pipe_reg[pmcl_pkg::TX_LINE_CYC-1];

   ////////////////////////////////////////////////////////////////////////////
   // 10BASE-T link integrity

   logic [LW-1:0] lnk_rx_cnt_reg;
   logic [LW-1:0] lnk_rx_cnt_next;
   logic [LW-1:0] lnk_tx_cnt_reg;
   logic [LW-1:0] lnk_tx_cnt_next;
   logic          link_up_reg;
   logic          link_up_next;
   logic          pulse_reg;
   logic          pulse_next;
   logic          rx_activity;

   assign rx_activity = sym_take && rx_sym_kind_i != pmcl_pkg::SYM_IDLE;

   always_comb begin
      lnk_rx_cnt_next = lnk_rx_cnt_reg;
      lnk_tx_cnt_next = lnk_tx_cnt_reg + LW'(1);
      link_up_next    = link_up_reg;
      pulse_next      = 1'b0;
      if (speed_100_i) begin
         lnk_rx_cnt_next = '0;
         lnk_tx_cnt_next = '0;
         link_up_next    = 1'b1;
      end else begin
         if (lnk_rx_cnt_reg != LW'(LINK_LOSS_CYC)) begin
            lnk_rx_cnt_next = lnk_rx_cnt_reg + LW'(1);
         end
         if (rx_activity || (line_link_pulse_i && lnk_rx_cnt_reg >= LW'(LINK_MIN_RX_CYC))) begin
            lnk_rx_cnt_next = '0;
            link_up_next    = 1'b1;
         end else if (lnk_rx_cnt_reg == LW'(LINK_LOSS_CYC)) begin
            link_up_next = 1'b0;
         end
         if (tx_s2_reg) begin
            lnk_tx_cnt_next = '0;
         end else if (lnk_tx_cnt_reg == LW'(LINK_TX_CYC - 1)) begin
            lnk_tx_cnt_next = '0;
            pulse_next      = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lnk_rx_cnt_reg <= '0;
         lnk_tx_cnt_reg <= '0;
         link_up_reg    <= 1'b0;
         pulse_reg      <= 1'b0;
      end else begin
         lnk_rx_cnt_reg <= lnk_rx_cnt_next;
         lnk_tx_cnt_reg <= lnk_tx_cnt_next;
         link_up_reg    <= link_up_next;
         pulse_reg      <= pulse_next;
      end
   end

   assign link_pulse_o = pulse_reg;
   assign link_up_o    = link_up_reg;

endmodule

// >>> logic/pmcl_pkg.sv
package pmcl_pkg;

   localparam int CLK_PERIOD_NS = 4;
   localparam int BIT_TIME_NS   = 10;
   localparam int SYNC_STAGES   = 2;

   // Receive targets in bit times (each inside its allowed window)
   localparam int RX_CRS_ON_BT  = 17;
   localparam int RX_CRS_OFF_BT = 20;
   localparam int RX_DV_LAG_BT  = 8;
   // Transmit line latency target in bit times
   localparam int TX_LINE_BT    = 9;

   localparam int RX_CNT_W = 6;
   localparam logic [RX_CNT_W-1:0] RX_CRS_ON_CYC  = RX_CNT_W'((RX_CRS_ON_BT * BIT_TIME_NS) / CLK_PERIOD_NS);
   localparam logic [RX_CNT_W-1:0] RX_CRS_OFF_CYC = RX_CNT_W'((RX_CRS_OFF_BT * BIT_TIME_NS) / CLK_PERIOD_NS);
   localparam logic [RX_CNT_W-1:0] RX_DV_LAG_CYC  = RX_CNT_W'((RX_DV_LAG_BT * BIT_TIME_NS) / CLK_PERIOD_NS);
   localparam logic [RX_CNT_W-1:0] RX_CNT_ONE     = RX_CNT_W'(1);
   localparam logic [RX_CNT_W-1:0] RX_CNT_ZERO    = RX_CNT_W'(0);
   // Tx delay line length; the synchroniser already contributes its stages
   localparam int TX_LINE_CYC = (TX_LINE_BT * BIT_TIME_NS) / CLK_PERIOD_NS - SYNC_STAGES;

   // 10BASE-T link integrity times in milliseconds
   localparam int LINK_TX_MS       = 16;
   localparam int LINK_MIN_RX_MS   = 4;
   localparam int LINK_LOSS_MS     = 100;
   localparam int NS_PER_MS        = 1000000;
   localparam int CYC_PER_MS       = NS_PER_MS / CLK_PERIOD_NS;
   localparam int LINK_CNT_W       = 25;

   // Line symbol kinds from the receive recovery logic
   localparam logic [1:0] SYM_IDLE = 2'h0;
   localparam logic [1:0] SYM_J    = 2'h1;
   localparam logic [1:0] SYM_T    = 2'h2;
   localparam logic [1:0] SYM_DATA = 2'h3;

   // Buffer word: {data valid, nibble}
   localparam int NIB_W  = 4;
   localparam int WORD_W = NIB_W + 1;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_WAIT_CRS,
      RX_CARRIER,
      RX_END_WAIT
   } pmcl_rx_state_type;

endpackage

// >>> verification/pmcl_phy_link_properties.sv
`timescale 1ns/1ps
module pmcl_phy_link_properties #(
   parameter int unsigned LINK_LOSS_CYC = 100
) (
   input wire logic                       clk_i,
   input wire logic                       sys_rst_i,
   input wire logic                       link_clk_i,
   input wire logic                       speed_100_i,
   input wire logic                       tx_en_i,
   input wire logic                       rx_sym_valid_i,
   input wire logic [1:0]                 rx_sym_kind_i,
   input wire logic [pmcl_pkg::NIB_W-1:0] rx_sym_data_i,
   input wire logic                       line_link_pulse_i,
   input wire logic                       rx_sym_ready_o,
   input wire logic                       crs_o,
   input wire logic                       col_o,
   input wire logic                       twisted_pair_out_positive_o,
   input wire logic                       link_pulse_o,
   input wire logic                       link_up_o,
   input wire logic [pmcl_pkg::NIB_W-1:0] rxd_o,
   input wire logic                       rx_dv_o
);
   logic tx_seen_reg;
   logic tx_seen_next;
   int   quiet_reg;
   int   quiet_next;
   logic taken;
   logic is_j;
   logic is_t;

   assign taken = rx_sym_valid_i && rx_sym_ready_o;
   assign is_j  = taken && rx_sym_kind_i == pmcl_pkg::SYM_J;
   assign is_t  = taken && rx_sym_kind_i == pmcl_pkg::SYM_T;

   // Quiet time counts any activity, so it is never stricter than the device
   always_comb begin
      tx_seen_next = tx_en_i;
      quiet_next   = (quiet_reg < int'(LINK_LOSS_CYC) + 8) ? quiet_reg + 1 : quiet_reg;
      if (sys_rst_i || speed_100_i || line_link_pulse_i || (taken && rx_sym_kind_i != pmcl_pkg::SYM_IDLE)) begin
         quiet_next = 0;
      end
   end
   always_ff @(posedge link_clk_i) begin
      tx_seen_reg <= tx_seen_next;
   end
   always_ff @(posedge clk_i) begin
      quiet_reg <= quiet_next;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

////////////////////////////////////////////////////////////////////////
   AST_DV_LAG: assert property ($rose(rx_dv_o) |-> $past(crs_o, 20))
      else $error("receive data valid too soon after carrier");
   AST_CRS_RX_ON: assert property (is_j && !crs_o |-> ##[1:50] crs_o)
      else $error("carrier late after start symbol");
   AST_CRS_RX_OFF: assert property (is_t && crs_o && !tx_seen_reg |-> ##[34:70] $fell(crs_o))
      else $error("carrier drop outside window after end symbol");
   AST_COL_ON: assert property (is_j && tx_seen_reg && !col_o |-> ##[1:50] col_o)
      else $error("collision late after start symbol");
   AST_COL_OFF: assert property (is_t && col_o |-> ##[34:70] $fell(col_o))
      else $error("collision drop outside window after end symbol");
   AST_CRS_TX_ON: assert property ($rose(tx_seen_reg) |-> ##[1:10] crs_o)
      else $error("carrier late after transmit enable");
   AST_CRS_TX_OFF: assert property ($fell(tx_seen_reg) && !col_o |-> ##[1:40] !crs_o)
      else $error("carrier held too long after transmit enable");
   AST_LINE_OUT: assert property ($rose(tx_seen_reg) |-> ##[16:34] $rose(twisted_pair_out_positive_o))
      else $error("line output outside latency window");
   AST_LINK_LOSS: assert property (quiet_reg >= int'(LINK_LOSS_CYC) + 4 |-> !link_up_o)
      else $error("link kept up without activity");
   AST_PULSE_10M: assert property (link_pulse_o |-> !speed_100_i ##1 !link_pulse_o)
      else $error("link pulse malformed or in fast mode");
endmodule

bind pmcl_phy_link pmcl_phy_link_properties #(.LINK_LOSS_CYC(LINK_LOSS_CYC)) i_pmcl_phy_link_properties (
   .clk_i, .sys_rst_i, .link_clk_i, .speed_100_i, .tx_en_i, .rx_sym_valid_i, .rx_sym_kind_i,
   .rx_sym_data_i, .line_link_pulse_i, .rx_sym_ready_o, .crs_o, .col_o, .twisted_pair_out_positive_o,
   .link_pulse_o, .link_up_o, .rxd_o, .rx_dv_o);

// >>> verification/pmcl_mac_model.sv
`timescale 1ns/1ps
module pmcl_mac_model (
   input  wire logic                       link_clk_i,
   input  wire logic [pmcl_pkg::NIB_W-1:0] rxd_i,
   input  wire logic                       rx_dv_i,
   output logic                            tx_en_o
);
   logic [3:0] got_q[$];
   logic [3:0] rxd_prev;
   logic       dv_prev;

   initial tx_en_o = 1'b0;

   // enable moves just after a nibble clock edge
   task automatic set_tx(input logic v);
      @(posedge link_clk_i);
      tx_en_o <= v;
   endtask

   // A word is held for several clocks, so only a change marks a new nibble
   always @(posedge link_clk_i) begin
      if (rx_dv_i === 1'b1 && (dv_prev !== 1'b1 || rxd_i !== rxd_prev)) got_q.push_back(rxd_i);
      dv_prev  <= rx_dv_i;
      rxd_prev <= rxd_i;
   end
endmodule

// >>> verification/pmcl_phy_link_bench.sv
`timescale 1ns/1ps
module pmcl_phy_link_bench;
   logic       clk_i             = 1'b0;
   logic       link_clk_i        = 1'b0;
   logic       sys_rst_i         = 1'b1;
   logic       speed_100_i       = 1'b1;
   logic       tx_en_i;
   logic       rx_sym_valid_i    = 1'b0;
   logic [1:0] rx_sym_kind_i     = 2'h0;
   logic [3:0] rx_sym_data_i     = 4'h0;
   logic       line_link_pulse_i = 1'b0;
   logic       rx_sym_ready_o;
   logic       crs_o;
   logic       col_o;
   logic       twisted_pair_out_positive_o;
   logic       link_pulse_o;
   logic       link_up_o;
   logic [3:0] rxd_o;
   logic       rx_dv_o;
   logic       saw_full = 1'b0;
   logic       saw_col  = 1'b0;
   int         pulses   = 0;
   int         p0;
   int         fails    = 0;
   int         compares = 0;
   logic [3:0] exp_q[$];

   always #2 clk_i = ~clk_i;
   always #62.5 link_clk_i = ~link_clk_i;

   pmcl_phy_link #(.LINK_TX_CYC(40), .LINK_MIN_RX_CYC(10), .LINK_LOSS_CYC(100)) i_pmcl_phy_link (
      .clk_i, .sys_rst_i, .link_clk_i, .speed_100_i, .tx_en_i, .rx_sym_valid_i, .rx_sym_kind_i,
      .rx_sym_data_i, .line_link_pulse_i, .rx_sym_ready_o, .crs_o, .col_o, .twisted_pair_out_positive_o,
      .link_pulse_o, .link_up_o, .rxd_o, .rx_dv_o);
   pmcl_mac_model i_pmcl_mac_model (.link_clk_i, .rxd_i(rxd_o), .rx_dv_i(rx_dv_o), .tx_en_o(tx_en_i));

   always @(posedge clk_i) begin
      if (col_o === 1'b1) saw_col <= 1'b1;
      if (link_pulse_o === 1'b1) pulses <= pulses + 1;
   end

////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Entered at a rising edge; returns at the edge where the symbol is taken
   task automatic sym(input logic [1:0] k, input logic [3:0] d);
      logic r;
      rx_sym_valid_i <= 1'b1;
      rx_sym_kind_i  <= k;
      rx_sym_data_i  <= d;
      do begin
         @(negedge clk_i);
         r = rx_sym_ready_o;
         if (r !== 1'b1) saw_full = 1'b1;
         @(posedge clk_i);
      end while (r !== 1'b1);
   endtask

   task automatic rx_frame(input int n);
      logic [3:0] d;
      int         t;
      d = 4'h0;
      @(posedge clk_i);
      sym(pmcl_pkg::SYM_DATA, 4'h5);
      sym(pmcl_pkg::SYM_J, 4'h0);
      for (int i = 0; i < n; i++) begin
         d = d + 4'(1 + $urandom_range(14));
         exp_q.push_back(d);
         sym(pmcl_pkg::SYM_DATA, d);
      end
      sym(pmcl_pkg::SYM_T, d);
      rx_sym_valid_i <= 1'b0;
      t = 0;
      while (t < 8000 && (i_pmcl_mac_model.got_q.size() < exp_q.size() || rx_dv_o !== 1'b0)) begin
         @(posedge clk_i);
         t++;
      end
      check(i_pmcl_mac_model.got_q.size(), exp_q.size());
      foreach (exp_q[i]) check(i_pmcl_mac_model.got_q[i], exp_q[i]);
      exp_q.delete();
      i_pmcl_mac_model.got_q.delete();
   endtask

////////////////////////////////////////////////////////////////////////
   // Longest path is a few thousand cycles, so this only fires on a hang
   initial begin
      repeat (60000) @(posedge clk_i);
      fails++;
      close_out();
   end

   initial begin
      void'($urandom(32'h691D));
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // The link side leaves reset a few nibble clocks after clk_i does
      repeat (4) @(posedge link_clk_i);
      rx_frame(4 + $urandom_range(4));
      check(saw_full, 1'b1);
      check(saw_col, 1'b0);
      i_pmcl_mac_model.set_tx(1'b1);
      repeat (2) @(posedge link_clk_i);
      check(crs_o, 1'b1);
      check(twisted_pair_out_positive_o, 1'b1);
      rx_frame(3);
      check(saw_col, 1'b1);
      check(col_o, 1'b0);
      i_pmcl_mac_model.set_tx(1'b0);
      repeat (2) @(posedge link_clk_i);
      check(crs_o, 1'b0);
      check(twisted_pair_out_positive_o, 1'b0);
      @(posedge clk_i);
      speed_100_i <= 1'b0;
      // The train outlasts the loss window, so only accepted pulses keep the link
      repeat (6) begin
         repeat (20) @(posedge clk_i);
         line_link_pulse_i <= 1'b1;
         @(posedge clk_i);
         line_link_pulse_i <= 1'b0;
      end
      repeat (3) @(posedge clk_i);
      check(link_up_o, 1'b1);
      p0 = pulses;
      // Too soon after the last pulse: must not restart the loss timer
      line_link_pulse_i <= 1'b1;
      @(posedge clk_i);
      line_link_pulse_i <= 1'b0;
      repeat (99) @(posedge clk_i);
      check(link_up_o, 1'b0);
      repeat (300) @(posedge clk_i);
      check(link_up_o, 1'b0);
      check(pulses - p0 >= 9 && pulses - p0 <= 11, 1'b1);
      close_out();
   end
endmodule
